// ==== cprl_lookup.sv ====
// Top of the user pattern RAM lookup: display fetch, cursor overlay, host access and timing.
`timescale 1ns/1ps
module cprl_lookup (
	input  wire logic       clk_sys_i,      // System clock, 125 MHz.
	input  wire logic       rst_n_i,        // Asynchronous reset, active low.
	input  wire logic       font_tall_i,    // High selects the eleven-row font.
	input  wire logic       cursor_on_i,    // Cursor display enabled.
	input  wire logic [6:0] cursor_pos_i,   // Character position of the cursor.
	output logic      [6:0] text_addr_o,    // Display text RAM address.
	input  wire logic [7:0] text_code_i,    // Character code, valid the cycle after the address.
	output logic      [7:0] rom_code_o,     // Code passed to the fixed pattern ROM.
	output logic      [3:0] rom_row_o,      // Row passed to the fixed pattern ROM.
	input  wire logic [4:0] rom_pix_i,      // ROM pixels, valid in the same cycle as the code.
	input  wire logic       host_req_i,     // Host access request, one-cycle pulse.
	input  wire logic       host_we_i,      // High for a write.
	input  wire logic [5:0] host_addr_i,    // Host pattern RAM address.
	input  wire logic [7:0] host_wdata_i,   // Host write data.
	output logic            host_busy_o,    // Host access pending.
	output logic            host_done_o,    // Host access finished, one-cycle pulse.
	output logic      [7:0] host_rdata_o,   // Host read data, valid with done.
	output logic      [4:0] pix_o,          // Pixel row of one character.
	output logic            pix_valid_o,    // Pixel row strobe.
	output logic            shift_clk_o,    // Cascade shift strobe.
	output logic            row_latch_o,    // Cascade row latch strobe.
	output logic      [3:0] row_o           // Common row being driven.
);

	// ****************************************
	// Timing generator
	// ****************************************
	cprl_pkg::cprl_phase_e phase;
	logic [6:0]            char_pos;
	logic [6:0]            next_char_pos;
	logic [3:0]            row;
	logic [3:0]            row_last;

	assign row_last      = font_tall_i ? cprl_pkg::ROW_LAST_TALL : cprl_pkg::ROW_LAST_SHORT;
	assign next_char_pos = (char_pos == cprl_pkg::TEXT_LAST) ? 7'h 00 : char_pos + 7'h 01;

	// Every character gets a fixed four-slot frame; the last slot is reserved
	// for the host so display fetches never wait on the host.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase    <= cprl_pkg::CPRL_PH_TEXT;
			char_pos <= '0;
			row      <= cprl_pkg::ROW_TOP;
		end else begin
			case (phase)
				cprl_pkg::CPRL_PH_TEXT: phase <= cprl_pkg::CPRL_PH_PAT;
				cprl_pkg::CPRL_PH_PAT:  phase <= cprl_pkg::CPRL_PH_OUT;
				cprl_pkg::CPRL_PH_OUT:  phase <= cprl_pkg::CPRL_PH_HOST;
				cprl_pkg::CPRL_PH_HOST: begin
					phase    <= cprl_pkg::CPRL_PH_TEXT;
					char_pos <= next_char_pos;
					if (char_pos == cprl_pkg::TEXT_LAST) begin
						row <= (row >= row_last) ? cprl_pkg::ROW_TOP : row + 4'h 1;
					end
				end
				default: phase <= cprl_pkg::CPRL_PH_TEXT;
			endcase
		end
	end

	// ****************************************
	// Address formation
	// ****************************************
	function automatic logic [5:0] user_addr(input logic tall, input logic [7:0] code,
		input logic [3:0] r);
		if (tall) begin
			user_addr = {code[2:1], r};
		end else begin
			user_addr = {code[2:0], r[2:0]};
		end
	endfunction : user_addr

	function automatic logic is_user(input logic [7:0] code);
		is_user = (code[7:4] == cprl_pkg::USER_CODE_HI);
	endfunction : is_user

	logic [7:0] code_q;
	logic       cursor_here;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			code_q      <= '0;
			cursor_here <= 1'b0;
		end else if (phase == cprl_pkg::CPRL_PH_PAT) begin
			code_q      <= text_code_i;
			cursor_here <= cursor_on_i && (cursor_pos_i == char_pos);
		end
	end

	// The text code first stands in the pattern slot, so the display read of the
	// pattern RAM takes it straight from the text memory there. Latching it first
	// would cost a slot and push the pixel data past the output slot.
	logic [7:0] disp_code;

	always_comb begin
		disp_code = code_q;
		if (phase == cprl_pkg::CPRL_PH_PAT) begin
			disp_code = text_code_i;
		end
	end

	// ****************************************
	// Host arbitration
	// ****************************************
	logic       pend;
	logic       pend_we;
	logic [5:0] pend_addr;
	logic [7:0] pend_wdata;
	logic       host_slot;
	logic       host_rd_q;

	assign host_slot = (phase == cprl_pkg::CPRL_PH_HOST) && pend;

	// A request is held until the host slot; a second request while one is pending is ignored.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend       <= 1'b0;
			pend_we    <= 1'b0;
			pend_addr  <= '0;
			pend_wdata <= '0;
		end else if (host_req_i && !pend) begin
			pend       <= 1'b1;
			pend_we    <= host_we_i;
			pend_addr  <= host_addr_i;
			pend_wdata <= host_wdata_i;
		end else if (host_slot) begin
			pend <= 1'b0;
		end
	end

	logic       ram_we;
	logic [5:0] ram_addr;
	logic [7:0] ram_rdata;

	assign ram_we   = host_slot && pend_we;
	assign ram_addr = (phase == cprl_pkg::CPRL_PH_HOST) ? pend_addr
		: user_addr(font_tall_i, disp_code, row);

	cprl_pattern_ram u_ram (
		.clk_sys_i (clk_sys_i),
		.we_i      (ram_we),
		.addr_i    (ram_addr),
		.wdata_i   (pend_wdata),
		.rdata_o   (ram_rdata)
	);

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_rd_q    <= 1'b0;
			host_done_o  <= 1'b0;
			host_busy_o  <= 1'b0;
			host_rdata_o <= '0;
		end else begin
			host_rd_q   <= host_slot;
			host_done_o <= host_rd_q;
			// Busy also covers the slot itself, so it falls exactly with the done pulse.
			host_busy_o <= (pend && !host_slot) || (host_req_i && !pend) || host_slot;
			if (host_rd_q) begin
				host_rdata_o <= ram_rdata;
			end
		end
	end

	// ****************************************
	// Display output
	// ****************************************
	logic [4:0] pix_sel;

	// The RAM was read in the pattern slot, so its data is steady in the output slot.
	always_comb begin
		pix_sel = is_user(code_q) ? ram_rdata[4:0] : rom_pix_i;
		if (cursor_here && row == row_last) begin
			pix_sel = pix_sel | cprl_pkg::PIX_CURSOR;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			text_addr_o <= '0;
			rom_code_o  <= '0;
			rom_row_o   <= '0;
			pix_o       <= cprl_pkg::PIX_BLANK;
			pix_valid_o <= 1'b0;
			shift_clk_o <= 1'b0;
			row_latch_o <= 1'b0;
			row_o       <= '0;
		end else begin
			// The address leads by one slot, so the text code stands in the pattern slot.
			text_addr_o <= (phase == cprl_pkg::CPRL_PH_HOST) ? next_char_pos : char_pos;
			rom_code_o  <= text_code_i;
			rom_row_o   <= row;
			pix_valid_o <= (phase == cprl_pkg::CPRL_PH_OUT);
			shift_clk_o <= (phase == cprl_pkg::CPRL_PH_OUT);
			row_latch_o <= (phase == cprl_pkg::CPRL_PH_HOST) && (char_pos == cprl_pkg::TEXT_LAST);
			row_o       <= row;
			if (phase == cprl_pkg::CPRL_PH_OUT) begin
				pix_o <= pix_sel;
			end
		end
	end

endmodule : cprl_lookup

// ==== cprl_pkg.sv ====
// Package of constants and types for the user pattern RAM lookup.
package cprl_pkg;

	// ****************************************
	// Memory geometry
	// ****************************************
	localparam int unsigned RAM_DEPTH     = 64;
	localparam int unsigned ADDR_W        = 6;
	localparam int unsigned DATA_W        = 8;
	localparam int unsigned PIX_W         = 5;
	localparam int unsigned ROW_W         = 4;
	localparam int unsigned CODE_W        = 8;
	localparam int unsigned TEXT_ADDR_W   = 7;
	localparam int unsigned TEXT_DEPTH    = 80;

	// ****************************************
	// Row numbers and fonts
	// ****************************************
	localparam logic [3:0] ROW_LAST_TALL  = 4'h a;
	localparam logic [3:0] ROW_LAST_SHORT = 4'h 7;
	localparam logic [3:0] ROW_TOP        = 4'h 0;
	localparam logic [3:0] USER_CODE_HI   = 4'h 0;
	localparam logic [6:0] TEXT_LAST      = 7'h 4f;
	localparam logic [4:0] PIX_CURSOR     = 5'h 1f;
	localparam logic [4:0] PIX_BLANK      = 5'h 00;

	// ****************************************
	// Timing of the display sequence
	// ****************************************
	localparam logic [1:0] SLOT_LAST      = 2'h 3;

	typedef enum logic [1:0] {
		CPRL_PH_TEXT,
		CPRL_PH_PAT,
		CPRL_PH_OUT,
		CPRL_PH_HOST
	} cprl_phase_e;

endpackage : cprl_pkg

// ==== cprl_pattern_ram.sv ====
// Single-port user pattern RAM, 64 bytes, all eight bits stored.
`timescale 1ns/1ps
module cprl_pattern_ram (
	input  wire logic       clk_sys_i,   // System clock.
	input  wire logic       we_i,        // Write strobe.
	input  wire logic [5:0] addr_i,      // Byte address.
	input  wire logic [7:0] wdata_i,     // Write data.
	output logic      [7:0] rdata_o      // Registered read data.
);

	logic [7:0] mem [cprl_pkg::RAM_DEPTH];

	// Bits 7:5 are kept so the host gets them back unchanged.
	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end

endmodule : cprl_pattern_ram

// ==== cprl_lookup_assertions.sv ====
// Port assertions for the user pattern RAM lookup.
`timescale 1ns/1ps
module cprl_lookup_assertions (
	input wire logic       clk_sys_i,    // Clock.
	input wire logic       rst_n_i,      // Reset, active low.
	input wire logic       font_tall_i,  // Font select.
	input wire logic       host_req_i,   // Host request.
	input wire logic       host_busy_o,  // Host busy.
	input wire logic       host_done_o,  // Host done.
	input wire logic [7:0] host_rdata_o, // Host read data.
	input wire logic [4:0] pix_o,        // Pixel row.
	input wire logic       pix_valid_o,  // Pixel strobe.
	input wire logic       shift_clk_o,  // Shift strobe.
	input wire logic       row_latch_o,  // Row latch strobe.
	input wire logic [3:0] row_o         // Common row.
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	// The display cadence must not stretch when the host steals a slot.
	sequence s_char_gap;
		!pix_valid_o [*3] ##1 pix_valid_o;
	endsequence
	chk_shift_strobe: assert property (shift_clk_o == pix_valid_o)
		else $error("shift strobe differs from pixel strobe");
	chk_strobe_period: assert property (pix_valid_o |=> s_char_gap)
		else $error("pixel strobe period broken");
	chk_req_taken: assert property (host_req_i && !host_busy_o |=> host_busy_o)
		else $error("host request not taken");
	chk_busy_bound: assert property ($rose(host_busy_o) |-> ##[1:6] host_done_o)
		else $error("host access not finished in time");
	chk_done_pulse: assert property (host_done_o |-> !host_busy_o ##1 !host_done_o)
		else $error("done not a single pulse");
	chk_tall_rows: assert property (font_tall_i |-> row_o <= 4'h a)
		else $error("tall font row out of range");
	chk_short_rows: assert property (!font_tall_i |-> row_o <= 4'h 7)
		else $error("short font row out of range");
	chk_pix_hold: assert property (!pix_valid_o |-> $stable(pix_o))
		else $error("pixels changed without strobe");
	chk_rdata_hold: assert property (!host_done_o |-> $stable(host_rdata_o))
		else $error("read data changed without done");
	chk_latch_after_pix: assert property (row_latch_o |-> $past(pix_valid_o))
		else $error("row latch not after last pixel strobe");
	chk_row_on_latch: assert property ($changed(row_o) |-> $past(row_latch_o))
		else $error("row changed without row latch");
endmodule : cprl_lookup_assertions

// ==== cprl_text_model.sv ====
// Text memory and fixed pattern memory facing the lookup.
`timescale 1ns/1ps
module cprl_text_model (
	input  wire logic       clk_sys_i,  // Clock.
	input  wire logic [6:0] addr_i,     // Text address.
	output logic      [7:0] code_o,     // Code, one cycle after address.
	input  wire logic [7:0] rom_code_i, // Fixed pattern code.
	input  wire logic [3:0] rom_row_i,  // Fixed pattern row.
	output logic      [4:0] rom_pix_o   // Fixed pattern pixels.
);
	// Code equals position, so positions 0 to 15 hit the user RAM.
	always_ff @(posedge clk_sys_i) begin
		code_o <= {1'b0, addr_i};
	end
	assign rom_pix_o = rom_code_i[4:0] ^ {1'b0, rom_row_i};
endmodule : cprl_text_model

// ==== testbench.sv ====
// Self-checking bench for the user pattern RAM lookup.
`timescale 1ns/1ps
module testbench;
	logic clk_sys_i = 0, rst_n_i = 0, font_tall_i = 1, cursor_on_i = 1, host_req_i = 0, host_we_i = 0;
	logic [6:0] cursor_pos_i = 0, text_addr_o;
	logic [7:0] text_code_i, rom_code_o, host_wdata_i = 0, host_rdata_o, c, mem [64];
	logic [5:0] host_addr_i = 0;
	logic [3:0] rom_row_o, row_o, row = 0;
	logic [4:0] rom_pix_i, pix_o, e;
	logic host_busy_o, host_done_o, pix_valid_o, shift_clk_o, row_latch_o, chk_on = 0, latch_due = 0;
	logic [8:0] exp_q [$];
	int fail_count = 0, compares = 0, seed = 32'h78aed2fa, pos = 0, a;
	always #4 clk_sys_i = ~clk_sys_i;
	cprl_lookup u_cprl_lookup (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .font_tall_i(font_tall_i),
		.cursor_on_i(cursor_on_i), .cursor_pos_i(cursor_pos_i), .text_addr_o(text_addr_o),
		.text_code_i(text_code_i), .rom_code_o(rom_code_o), .rom_row_o(rom_row_o), .rom_pix_i(rom_pix_i),
		.host_req_i(host_req_i), .host_we_i(host_we_i), .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i),
		.host_busy_o(host_busy_o), .host_done_o(host_done_o), .host_rdata_o(host_rdata_o), .pix_o(pix_o),
		.pix_valid_o(pix_valid_o), .shift_clk_o(shift_clk_o), .row_latch_o(row_latch_o), .row_o(row_o));
	cprl_text_model u_cprl_text_model (.clk_sys_i(clk_sys_i), .addr_i(text_addr_o), .code_o(text_code_i),
		.rom_code_i(rom_code_o), .rom_row_i(rom_row_o), .rom_pix_o(rom_pix_i));
	// ****
	// Tasks
	// ****
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task finish_test;
		if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	// Entered at a falling edge; the next request may start in the done cycle.
	task host(input logic we, input logic [5:0] ad, input logic [7:0] d);
		int i;
		host_req_i = 1;
		host_we_i = we;
		host_addr_i = ad;
		host_wdata_i = d;
		if (we) mem[ad] = d;
		exp_q.push_back({!we, mem[ad]});
		@(negedge clk_sys_i);
		host_req_i = 0;
		for (i = 0; i < 10 && host_done_o !== 1'b1; i++) @(negedge clk_sys_i);
		if (i == 10) fail_count++;
	endtask : host
	// ****
	// Watcher
	// ****
	always @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pos = 0;
			row = 0;
			latch_due = 0;
		end else begin
			chk({7'h00, row_latch_o}, {7'h00, latch_due});
			latch_due = 0;
			if (host_done_o === 1'b1) begin
				if (exp_q.size() == 0) begin
					chk(8'h01, 8'h00);
				end else begin
					if (exp_q[0][8]) chk(host_rdata_o, exp_q[0][7:0]);
					void'(exp_q.pop_front());
				end
			end
			if (pix_valid_o === 1'b1) begin
				c = pos[7:0];
				if (c[7:4] == 4'h0) e = mem[font_tall_i ? {c[2:1], row} : {c[2:0], row[2:0]}][4:0];
				else e = c[4:0] ^ {1'b0, row};
				if (cursor_on_i && pos == cursor_pos_i && row == (font_tall_i ? 4'ha : 4'h7)) e = e | 5'h1f;
				if (chk_on) chk({3'h0, pix_o}, {3'h0, e});
				chk({4'h0, row_o}, {4'h0, row});
				pos++;
				if (pos == 80) begin
					pos = 0;
					latch_due = 1;
					row = (row == (font_tall_i ? 4'ha : 4'h7)) ? 4'h0 : row + 4'h1;
				end
			end
		end
	end
	initial begin
		#200us;
		fail_count++;
		finish_test();
	end
	initial begin
		cursor_pos_i = 7'($unsigned($random(seed)) % 16);
		repeat (5) @(negedge clk_sys_i);
		rst_n_i = 1;
		for (a = 0; a < 64; a++) begin
			c = $random(seed);
			host(1, a[5:0], (a[3:0] == 4'ha) ? (c & 8'he0) : c);
		end
		chk_on = 1;
		for (a = 0; a < 64; a++) host(0, a[5:0], 8'h00);
		repeat (7200) @(negedge clk_sys_i);
		rst_n_i = 0;
		font_tall_i = 0;
		cursor_pos_i = 7'($unsigned($random(seed)) % 16);
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1;
		repeat (5300) @(negedge clk_sys_i);
		rst_n_i = 0;
		font_tall_i = 1;
		cursor_on_i = 0;
		repeat (2) @(negedge clk_sys_i);
		rst_n_i = 1;
		repeat (3600) @(negedge clk_sys_i);
		finish_test();
	end
endmodule : testbench
bind cprl_lookup cprl_lookup_assertions u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.font_tall_i(font_tall_i), .host_req_i(host_req_i), .host_busy_o(host_busy_o),
	.host_done_o(host_done_o), .host_rdata_o(host_rdata_o), .pix_o(pix_o),
	.pix_valid_o(pix_valid_o), .shift_clk_o(shift_clk_o), .row_latch_o(row_latch_o), .row_o(row_o));
